// ### pbs_pkg.sv
// Purpose: shared constants and types of the pipelined burst SRAM port
// Assumes: one clock, synchronous active-low reset
// Notes: array depth is small on purpose so that simulation stays fast
package pbs_pkg;

   // =====================================================================
   // geometry
   localparam int ADDR_W = 10;
   localparam int DEPTH = 1 << ADDR_W;
   localparam int LANES = 4;
   localparam int LANE_W = 8;
   localparam int DATA_W = LANES * LANE_W;
   localparam int CELL_W = LANE_W + 1;
   localparam int WORD_W = LANES * CELL_W;
   localparam int CNT_W = 2;

   // =====================================================================
   // fixed values
   localparam logic [LANES-1:0] LANE_ALL = 4'hF;
   localparam logic [LANES-1:0] LANE_NONE = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ZERO = 2'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 2'h1;
   localparam logic [WORD_W-1:0] WORD_RST = 36'h0;
   localparam logic [ADDR_W-1:0] ADDR_RST = 10'h0;
   // strap level that picks the linear order; the pull-up gives the other
   localparam logic STRAP_LINEAR = 1'b0;
   localparam logic STRAP_RST = 1'b1;

   typedef enum logic [1:0]
   {
      PBS_DESEL = 2'b01,
      PBS_SEL = 2'b10
   } pbs_state_t;

endpackage

// ### pbs_burst_if.sv
// Purpose: carries burst counter control and result between modules
// Assumes: both ends on ref_clk
// Notes: next_low is the address that an advance would step to
`timescale 1ns/1ps
interface pbs_burst_if;
   import pbs_pkg::*;
   logic load;
   logic advance;
   logic linear;
   logic [CNT_W-1:0] seed;
   logic [CNT_W-1:0] cur_low;
   logic [CNT_W-1:0] next_low;

   modport ctl
   (
      output load,
      output advance,
      output linear,
      output seed,
      input cur_low,
      input next_low
   );

   modport cnt
   (
      input load,
      input advance,
      input linear,
      input seed,
      output cur_low,
      output next_low
   );
endinterface

// ### pbs_burst_counter.sv
// Purpose: two-bit wraparound burst counter, linear or interleaved
// Assumes: load and advance never matter in the same cycle (load wins)
// Notes: keeps the start value and a step count; order is applied on read
`timescale 1ns/1ps
module pbs_burst_counter
(
   input wire logic ref_clk,
   input wire logic nrst,
   pbs_burst_if.cnt bus
);
   import pbs_pkg::*;

   logic [CNT_W-1:0] start;
   logic [CNT_W-1:0] step;
   logic [CNT_W-1:0] next_step;

   // =====================================================================
   // address order
   assign next_step = step + CNT_ONE;
   assign bus.cur_low = bus.linear ? start + step : start ^ step;
   assign bus.next_low = bus.linear ? start + next_step
                                    : start ^ next_step;

   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         start <= CNT_ZERO;
         step <= CNT_ZERO;
      end
      else if (bus.load)
      begin
         start <= bus.seed;
         step <= CNT_ZERO;
      end
      else if (bus.advance)
      begin
         step <= next_step;
      end
   end

   // =====================================================================
   // checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   a_seed_load: assert property (bus.load |=> bus.cur_low == $past(bus.seed))
      else $error("counter did not load the start address");

   a_step_next: assert property
      (bus.advance && !bus.load |=> bus.cur_low == $past(bus.next_low))
      else $error("counter did not step to the next address");

   a_linear_wrap: assert property
      (bus.load && bus.linear ##1 (bus.advance && bus.linear)[*3]
       |=> bus.cur_low == $past(bus.seed, 4) + 2'h3)
      else $error("linear order lost its count");
endmodule

// ### pbs_sram_port.sv
// Purpose: synchronous pipelined burst SRAM with common data pins
// Assumes: bus master keeps to the strobe and enable protocol
// Notes: data pins are split into in, out and an active-low drive enable
`timescale 1ns/1ps
// How it works
// - all inputs except output enable, and data outputs, are registered
// - data and parity pins captured on clock
// - driven data is the previously addressed word
// - output enable low drives, high tri-states
// - strap low linear, high or open interleaved
// - counter loads burst start, makes the rest
// - either strobe starts; only advance steps
// - global write writes all four lanes
// - byte write touches only selected lanes
// - processor strobe ignored while select one high
// - read: strobe, selected, no write enables
// - read data driven one edge later
// - first cycle out of deselect stays tri-stated
// - back-to-back single reads allowed
// - deselecting strobe tri-states outputs immediately
// - processor start ignores write and advance
// - processor write finishes on second edge
// - detected write cycle forces tri-state
// - array writes are timed internally
// - advance low steps the burst order
// - both strobes low: processor strobe wins
// - low bits seed; linear adds, interleaved xors
// - controller write completes in one cycle
module pbs_sram_port
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [pbs_pkg::ADDR_W-1:0] addr,
   input wire logic processor_addr_strobe_n,
   input wire logic controller_addr_strobe_n,
   input wire logic burst_step_n,
   input wire logic global_write_n,
   input wire logic byte_write_enable_n,
   input wire logic [pbs_pkg::LANES-1:0] byte_lane_select_n,
   input wire logic chip_select_primary_n,
   input wire logic chip_select_second_hi,
   input wire logic chip_select_third_n,
   input wire logic output_enable_n,
   input wire logic burst_order_strap,
   input wire logic [pbs_pkg::DATA_W-1:0] dq_in,
   output logic [pbs_pkg::DATA_W-1:0] dq_out,
   output logic dq_oe_n,
   input wire logic [pbs_pkg::LANES-1:0] parity_lane_pins_in,
   output logic [pbs_pkg::LANES-1:0] parity_lane_pins_out,
   output logic parity_lane_pins_oe_n
);
   import pbs_pkg::*;

   // =====================================================================
   // input registers
   logic [ADDR_W-1:0] s_addr;
   logic s_processor_addr_strobe_n_n;
   logic s_controller_addr_strobe_n_n;
   logic s_adv_n;
   logic s_gw_n;
   logic s_bwe_n;
   logic [LANES-1:0] s_bw_n;
   logic s_ce1_n;
   logic s_ce2;
   logic s_ce3_n;
   logic [DATA_W-1:0] s_dq;
   logic [LANES-1:0] s_par;

   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         s_addr <= ADDR_RST;
         s_processor_addr_strobe_n_n <= 1'b1;
         s_controller_addr_strobe_n_n <= 1'b1;
         s_adv_n <= 1'b1;
         s_gw_n <= 1'b1;
         s_bwe_n <= 1'b1;
         s_bw_n <= LANE_ALL;
         s_ce1_n <= 1'b1;
         s_ce2 <= 1'b0;
         s_ce3_n <= 1'b1;
         s_dq <= WORD_RST[DATA_W-1:0];
         s_par <= LANE_NONE;
      end
      else
      begin
         s_addr <= addr;
         s_processor_addr_strobe_n_n <= processor_addr_strobe_n;
         s_controller_addr_strobe_n_n <= controller_addr_strobe_n;
         s_adv_n <= burst_step_n;
         s_gw_n <= global_write_n;
         s_bwe_n <= byte_write_enable_n;
         s_bw_n <= byte_lane_select_n;
         s_ce1_n <= chip_select_primary_n;
         s_ce2 <= chip_select_second_hi;
         s_ce3_n <= chip_select_third_n;
         s_dq <= dq_in;
         s_par <= parity_lane_pins_in;
      end
   end

   // =====================================================================
   // burst order strap
   // static pin, still synchronised since it arrives from a board net
   logic strap_a;
   logic strap_b;
   logic strap_c;
   logic strap_lvl;

   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         strap_a <= STRAP_RST;
         strap_b <= STRAP_RST;
         strap_c <= STRAP_RST;
      end
      else
      begin
         strap_a <= burst_order_strap;
         strap_b <= strap_a;
         strap_c <= strap_b;
      end
   end

   // a strap moved mid-burst would reorder that burst; none is expected
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
         strap_lvl <= STRAP_RST;
      else if (strap_b == strap_c)
         strap_lvl <= strap_c;
   end

   // =====================================================================
   // access decode
   pbs_state_t state;
   logic p_start;
   logic c_start;
   logic load;
   logic sel_ok;
   logic new_acc;
   logic desel;
   logic cont;
   logic wr_req;
   logic do_write;
   logic do_read;
   logic advance;
   logic first_mask;
   logic [LANES-1:0] lane_we;
   logic [ADDR_W-1:0] eff_addr;

   pbs_burst_if bif ();

   assign p_start = !s_processor_addr_strobe_n_n && !s_ce1_n;
   assign c_start = !p_start && !s_controller_addr_strobe_n_n;
   assign load = p_start || c_start;
   assign sel_ok = !s_ce1_n && s_ce2 && !s_ce3_n;
   assign new_acc = load && sel_ok;
   assign desel = load && !sel_ok;
   assign cont = !load && (state == PBS_SEL);
   assign wr_req = !s_gw_n || !s_bwe_n;
   // processor start with all selects active is a read; its write comes on the next edge
   assign do_write = ((c_start && sel_ok) || cont) && wr_req;
   assign do_read = (p_start && sel_ok)
                    || (((c_start && sel_ok) || cont) && !wr_req);
   assign advance = cont && !s_adv_n;
   assign first_mask = new_acc && (state == PBS_DESEL);

   always_comb
   begin
      if (!s_gw_n)
         lane_we = LANE_ALL;
      else if (!s_bwe_n)
         lane_we = ~s_bw_n;
      else
         lane_we = LANE_NONE;
   end

   assign bif.load = new_acc;
   assign bif.seed = s_addr[CNT_W-1:0];
   assign bif.advance = advance;
   assign bif.linear = (strap_lvl == STRAP_LINEAR);

   pbs_burst_counter u_count
   (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .bus(bif)
   );

   logic [ADDR_W-1:CNT_W] hi_addr;

   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
         hi_addr <= ADDR_RST[ADDR_W-1:CNT_W];
      else if (new_acc)
         hi_addr <= s_addr[ADDR_W-1:CNT_W];
   end

   always_comb
   begin
      if (new_acc)
         eff_addr = s_addr;
      else if (advance)
         eff_addr = {hi_addr, bif.next_low};
      else
         eff_addr = {hi_addr, bif.cur_low};
   end

   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
         state <= PBS_DESEL;
      else
      begin
         case (state)
            PBS_DESEL:
               if (new_acc)
                  state <= PBS_SEL;
            PBS_SEL:
               if (desel)
                  state <= PBS_DESEL;
            default:
               state <= PBS_DESEL;
         endcase
      end
   end

   // =====================================================================
   // array and output register
   // no write pulse from outside: the edge after decode commits the lanes
   logic [CELL_W-1:0] mem [0:DEPTH-1][0:LANES-1];
   logic [WORD_W-1:0] rd_word;
   logic out_live;

   always_ff @(posedge ref_clk)
   begin
      if (do_write)
      begin
         for (int i = 0; i < LANES; i++)
         begin
            if (lane_we[i])
               mem[eff_addr][i] <= {s_par[i], s_dq[i*LANE_W +: LANE_W]};
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
         rd_word <= WORD_RST;
      else if (do_read)
      begin
         for (int i = 0; i < LANES; i++)
            rd_word[i*CELL_W +: CELL_W] <= mem[eff_addr][i];
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
         out_live <= 1'b0;
      else
         out_live <= do_read;
   end

   // =====================================================================
   // pins
   // enables stay combinational: output enable is an asynchronous input
   logic drive;

   assign drive = out_live && !output_enable_n
                  && !desel && !do_write && !first_mask;
   assign dq_oe_n = !drive;
   assign parity_lane_pins_oe_n = !drive;

   always_comb
   begin
      for (int i = 0; i < LANES; i++)
      begin
         dq_out[i*LANE_W +: LANE_W] = rd_word[i*CELL_W +: LANE_W];
         parity_lane_pins_out[i] = rd_word[i*CELL_W + LANE_W];
      end
   end

   // =====================================================================
   // checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   sequence p_begin;
      new_acc && p_start;
   endsequence

   sequence p_second_global;
      cont && !s_gw_n;
   endsequence

   sequence read_then_open;
      do_read ##1 (!output_enable_n && !desel && !do_write && !first_mask);
   endsequence

   a_oe_tristate: assert property (output_enable_n |-> dq_oe_n)
      else $error("data pins driven with output enable high");

   a_write_tristate: assert property (do_write |-> dq_oe_n)
      else $error("data pins driven during a write");

   a_desel_tristate: assert property
      (desel |-> dq_oe_n ##1 (state == PBS_DESEL))
      else $error("deselect did not tri-state at once");

   a_first_mask: assert property
      (new_acc && (state == PBS_DESEL) |-> dq_oe_n)
      else $error("pins driven in first cycle after deselect");

   a_read_drive: assert property (read_then_open |-> !dq_oe_n)
      else $error("read data not driven one edge later");

   a_processor_addr_strobe_n_ignored: assert property
      (s_ce1_n && s_controller_addr_strobe_n_n && (state == PBS_DESEL)
       |=> state == PBS_DESEL)
      else $error("processor strobe honoured with select one high");

   a_processor_addr_strobe_n_priority: assert property
      (!s_processor_addr_strobe_n_n && sel_ok |-> do_read && !do_write)
      else $error("processor start did not begin a read");

   a_two_cycle_write: assert property
      (p_begin ##1 p_second_global |-> do_write && lane_we == LANE_ALL)
      else $error("second edge global write missed");

   a_byte_lanes: assert property
      (do_write && s_gw_n |-> lane_we == ~s_bw_n)
      else $error("byte write used wrong lanes");

   a_controller_addr_strobe_n_write: assert property
      (c_start && sel_ok && wr_req |-> do_write)
      else $error("controller write not done in one cycle");

   a_lane_capture: assert property
      (do_write && lane_we[0] |=> mem[$past(eff_addr)][0]
       == $past({s_par[0], s_dq[LANE_W-1:0]}))
      else $error("written lane does not hold captured data");

   a_back_to_back: assert property (do_read[*2] |=> out_live[*1])
      else $error("consecutive reads lost output");
endmodule

// ### pbs_bus_master.sv
// Purpose: bus master model driving the burst SRAM port
// Assumes: requests change just after the falling clock edge
// Notes: a released data bus shows the inverse of its last level
`timescale 1ns/1ps
module pbs_bus_master
(
   input wire logic ref_clk,
   input wire logic [pbs_pkg::DATA_W-1:0] dq_out,
   input wire logic dq_oe_n,
   input wire logic [pbs_pkg::LANES-1:0] parity_lane_pins_out,
   input wire logic parity_lane_pins_oe_n,
   output logic [pbs_pkg::ADDR_W-1:0] addr,
   output logic processor_addr_strobe_n,
   output logic controller_addr_strobe_n,
   output logic burst_step_n,
   output logic global_write_n,
   output logic byte_write_enable_n,
   output logic [pbs_pkg::LANES-1:0] byte_lane_select_n,
   output logic chip_select_primary_n,
   output logic chip_select_second_hi,
   output logic chip_select_third_n,
   output logic output_enable_n,
   output logic burst_order_strap,
   output logic [pbs_pkg::DATA_W-1:0] dq_in,
   output logic [pbs_pkg::LANES-1:0] parity_lane_pins_in
);
   import pbs_pkg::*;
   logic drv = 1'h0;
   logic [WORD_W-1:0] wd = WORD_RST;
   logic [WORD_W-1:0] last = WORD_RST;
   logic [WORD_W-1:0] bus;

   // ==========
   // shared pins: a floating bus must not read back a stale value
   assign bus[DATA_W-1:0] = !dq_oe_n ? dq_out :
      drv ? wd[DATA_W-1:0] : ~last[DATA_W-1:0];
   assign bus[WORD_W-1:DATA_W] = !parity_lane_pins_oe_n ?
      parity_lane_pins_out : drv ? wd[WORD_W-1:DATA_W] :
      ~last[WORD_W-1:DATA_W];
   assign dq_in = bus[DATA_W-1:0];
   assign parity_lane_pins_in = bus[WORD_W-1:DATA_W];

   always_ff @(posedge ref_clk)
      last <= bus;

   // ==========
   // requests
   task automatic cyc(input logic [ADDR_W-1:0] a, input logic [4:0] k,
      input logic [LANES-1:0] l, input logic o, input logic d,
      input logic [WORD_W-1:0] w);
      addr = a;
      {processor_addr_strobe_n, controller_addr_strobe_n, burst_step_n,
         global_write_n, byte_write_enable_n} = k;
      byte_lane_select_n = l;
      output_enable_n = o;
      drv = d & o;
      wd = w;
   endtask

   task automatic sel(input logic [2:0] v);
      {chip_select_primary_n, chip_select_second_hi, chip_select_third_n} = v;
   endtask

   // only called just before reset is asserted
   task automatic strap(input logic v);
      burst_order_strap = v;
   endtask

   initial
   begin
      sel(3'h2);
      cyc(ADDR_RST, 5'h1F, LANE_ALL, 1'h1, 1'h0, WORD_RST);
   end
endmodule

// ### pbs_sram_port_tb.sv
// Purpose: self-checking bench of the burst SRAM port
// Assumes: the master model changes requests on the falling edge
// Notes: expected words come from a shadow array kept by the bench
`timescale 1ns/1ps
module pbs_sram_port_tb;
   import pbs_pkg::*;
   logic ref_clk, nrst;
   logic [ADDR_W-1:0] addr;
   logic processor_addr_strobe_n, controller_addr_strobe_n, burst_step_n;
   logic global_write_n, byte_write_enable_n, output_enable_n;
   logic chip_select_primary_n, chip_select_second_hi, chip_select_third_n;
   logic burst_order_strap, dq_oe_n, parity_lane_pins_oe_n;
   logic [LANES-1:0] byte_lane_select_n, parity_lane_pins_in;
   logic [LANES-1:0] parity_lane_pins_out;
   logic [DATA_W-1:0] dq_in, dq_out;
   logic [WORD_W-1:0] mem [DEPTH];
   logic [ADDR_W-1:0] pool [8];
   int errors = 0;
   int total_checks = 0;
   wire [1:0] oes = {dq_oe_n, parity_lane_pins_oe_n};
   wire [WORD_W-1:0] rd = {parity_lane_pins_out, dq_out};

   pbs_sram_port u_pbs_sram_port
   (
      .ref_clk, .nrst, .addr, .processor_addr_strobe_n,
      .controller_addr_strobe_n, .burst_step_n, .global_write_n,
      .byte_write_enable_n, .byte_lane_select_n, .chip_select_primary_n,
      .chip_select_second_hi, .chip_select_third_n, .output_enable_n,
      .burst_order_strap, .dq_in, .dq_out, .dq_oe_n, .parity_lane_pins_in,
      .parity_lane_pins_out, .parity_lane_pins_oe_n
   );

   pbs_bus_master u_pbs_bus_master
   (
      .ref_clk, .dq_out, .dq_oe_n, .parity_lane_pins_out,
      .parity_lane_pins_oe_n, .addr, .processor_addr_strobe_n,
      .controller_addr_strobe_n, .burst_step_n, .global_write_n,
      .byte_write_enable_n, .byte_lane_select_n, .chip_select_primary_n,
      .chip_select_second_hi, .chip_select_third_n, .output_enable_n,
      .burst_order_strap, .dq_in, .parity_lane_pins_in
   );

   initial
   begin
      ref_clk = 1'h0;
      forever #2 ref_clk = ~ref_clk;
   end

   // ==========
   // helpers
   task automatic chk(input string n, input logic [WORD_W-1:0] e,
      input logic [WORD_W-1:0] g);
      total_checks++;
      if (e !== g)
      begin
         errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic go(input logic [ADDR_W-1:0] a, input logic [4:0] k,
      input logic o, input logic d, input logic [WORD_W-1:0] w);
      u_pbs_bus_master.cyc(a, k, LANE_ALL, o, d, w);
   endtask

   function automatic logic [WORD_W-1:0] merge(input logic [WORD_W-1:0] o,
      input logic [WORD_W-1:0] w, input logic g, input logic [LANES-1:0] l);
      merge = o;
      for (int i = 0; i < LANES; i++)
         if (!g || !l[i])
         begin
            merge[LANE_W*i+:LANE_W] = w[LANE_W*i+:LANE_W];
            merge[DATA_W+i] = w[DATA_W+i];
         end
   endfunction

   function automatic logic [1:0] ord(input logic [1:0] s, input int n,
      input logic lin);
      ord = lin ? s + 2'(n) : s ^ 2'(n);
   endfunction

   task automatic do_reset(input logic st);
      u_pbs_bus_master.strap(st);
      nrst = 1'h0;
      repeat (16) @(negedge ref_clk);
      nrst = 1'h1;
      // let the strap synchroniser settle before the first request
      repeat (4) @(negedge ref_clk);
   endtask

   // back-to-back single reads of pool entries, data one edge late
   task automatic rds(input int lo, input int n);
      for (int i = 0; i < n + 2; i++)
      begin
         @(negedge ref_clk);
         if (i >= 2)
         begin
            chk("rdata", mem[pool[(lo+i-2)%8]], rd);
            chk("drive", 36'h0, oes);
         end
         go(pool[(lo+i)%8], {2'h2, i >= n, 2'h3}, 1'h0, 1'h0, 36'h0);
      end
   endtask

   // p picks the processor strobe; its start carries junk write controls
   task automatic wr(input int j, input logic p, input logic g,
      input logic [LANES-1:0] l);
      logic [WORD_W-1:0] w;
      w = 36'({$urandom(), $urandom()});
      @(negedge ref_clk);
      if (p)
      begin
         u_pbs_bus_master.cyc(pool[j], 5'h08, ~l, 1'h1, 1'h0, 36'h0);
         @(negedge ref_clk);
      end
      u_pbs_bus_master.cyc(pool[j], {p ? 2'h3 : 2'h2, p, g, 1'h0}, l,
         1'h1, 1'h1, w);
      @(negedge ref_clk);
      chk("wr_tri", 36'h3, oes);
      go(pool[j], 5'h1F, 1'h1, 1'h0, 36'h0);
      mem[pool[j]] = merge(mem[pool[j]], w, g, l);
   endtask

   task automatic burst(input logic [1:0] s, input logic lin);
      logic [ADDR_W-1:0] b;
      b = {pool[4][ADDR_W-1:2], s};
      for (int k = 0; k < 6; k++)
      begin
         @(negedge ref_clk);
         if (k >= 2)
            chk("burst", mem[{b[ADDR_W-1:2], ord(s, k-2, lin)}], rd);
         go(b, {k == 0 ? 2'h2 : 2'h3, k == 0 || k > 3, 2'h3}, 1'h0, 1'h0,
            36'h0);
      end
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ==========
   // tests
   initial
   begin
      logic [ADDR_W-3:0] b;
      void'($urandom(32'hC1A1FB90));
      do_reset(STRAP_RST);
      chk("reset", 36'h3, oes);
      b = (ADDR_W-2)'($urandom());
      for (int i = 0; i < 8; i++)
         pool[i] = i < 4 ? ADDR_W'($urandom()) : {b, 2'(i)};
      for (int i = 0; i < 8; i++)
         wr(i, 1'h0, 1'h0, LANE_ALL);
      rds(0, 8);
      for (int i = 0; i < 24; i++)
      begin
         b = (ADDR_W-2)'($urandom_range(7));
         wr(b, 1'($urandom()), $urandom_range(3) == 0, 4'($urandom()));
         rds(b, 1);
      end
      $display("test writes done");
      rds(0, 1);
      @(negedge ref_clk);
      go(pool[0], 5'h1F, 1'h1, 1'h0, 36'h0);
      #1;
      chk("oe_off", 36'h3, oes);
      go(pool[0], 5'h1F, 1'h0, 1'h0, 36'h0);
      #1;
      chk("oe_on", 36'h0, oes);
      @(negedge ref_clk);
      u_pbs_bus_master.sel(3'h0);
      go(pool[0], 5'h17, 1'h0, 1'h0, 36'h0);
      @(negedge ref_clk);
      chk("desel", 36'h3, oes);
      u_pbs_bus_master.sel(3'h2);
      go(pool[0], 5'h17, 1'h0, 1'h0, 36'h0);
      @(negedge ref_clk);
      chk("first", 36'h3, oes);
      go(pool[0], 5'h1F, 1'h0, 1'h0, 36'h0);
      @(negedge ref_clk);
      chk("after_oe", 36'h0, oes);
      u_pbs_bus_master.sel(3'h6);
      go(pool[1], 5'h0F, 1'h0, 1'h0, 36'h0);
      @(negedge ref_clk);
      u_pbs_bus_master.sel(3'h2);
      go(pool[1], 5'h1F, 1'h0, 1'h0, 36'h0);
      @(negedge ref_clk);
      chk("ignored", mem[pool[0]], rd);
      chk("ignored_oe", 36'h0, oes);
      go(pool[0], 5'h16, 1'h0, 1'h0, 36'h0);
      @(negedge ref_clk);
      chk("wr_oe_low", 36'h3, oes);
      go(pool[0], 5'h1F, 1'h0, 1'h0, 36'h0);
      rds(0, 1);
      @(negedge ref_clk);
      go(pool[1], 5'h04, 1'h1, 1'h1, 36'($urandom()));
      rds(1, 1);
      $display("test pins done");
      for (int s = 0; s < 4; s++)
         burst(2'(s), 1'h0);
      do_reset(STRAP_LINEAR);
      for (int s = 0; s < 4; s++)
         burst(2'(s), 1'h1);
      $display("test bursts done");
      print_verdict();
   end

   initial
   begin
      repeat (5000) @(posedge ref_clk);
      errors++;
      print_verdict();
   end
endmodule
